// *** logic/pal_consts.svh ***
// Constants for the port A low pin function selector.
// Assumes inclusion by bare name from the pal design files.
`ifndef PAL_CONSTS_SVH
`define PAL_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PAL_ADDR_W 8
`define PAL_OFS_FSEL 8'h00
`define PAL_OFS_P15 8'h04
`define PAL_OFS_STAT 8'h08

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PAL_FSEL_PIN3_LSB 12
`define PAL_FSEL_PIN2_LSB 8
`define PAL_FSEL_PIN1_LSB 4
`define PAL_FSEL_PIN0_LSB 0
`define PAL_FSEL_RW_MASK 16'h7777
`define PAL_FSEL_RESET 16'h0000
`define PAL_P15_CLK_BIT 0
`define PAL_STAT_SINGLE_BIT 0
`define PAL_STAT_CAUGHT_BIT 1
`define PAL_STAT_LEVEL_LSB 4
`define PAL_STAT_P15_LEVEL_BIT 8

// ----------------------------------------
// Timing and answers
// ----------------------------------------
`define PAL_STRAP_WAIT 2'h3
`define PAL_RESP_OKAY 2'h0
`define PAL_RESP_SLVERR 2'h2
`define PAL_IDLE_IN 1'b1

`endif

// *** logic/pal_pkg.sv ***
// Types shared by the port A low pin function selector.
// Assumes nothing beyond a SystemVerilog compiler.
package pal_pkg;

    // Function codes of a pin's three-bit field
    typedef enum logic [2:0] {
        PAL_FN_PORT = 3'h0,
        PAL_FN_ALT1 = 3'h1,
        PAL_FN_ALT3 = 3'h3,
        PAL_FN_ALT7 = 3'h7
    } pal_code_e;

    // Drive of one two-way pin
    typedef struct packed {
        logic dout;
        logic oe;
    } pal_drv_s;

    // One register write as seen by the register file
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pal_wr_s;

endpackage

// *** logic/pal_sync.sv ***
// Two-flop synchroniser, one lane per bit.
// Assumes asynchronous inputs and the system clock of the caller.
`timescale 1ns/1ns
`default_nettype none
module pal_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic meta;
            logic next_meta;
            logic stage;
            always_comb begin
                next_meta = i_async[g];
            end
            // First flop feeds only the second
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_b) begin
                    meta <= 1'b0;
                    stage <= 1'b0;
                end else begin
                    meta <= next_meta;
                    stage <= meta;
                end
            end
            assign o_sync[g] = stage;
        end
    endgenerate

endmodule
`default_nettype wire

// *** logic/pal_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file answers read data in the cycle it is asked.
`timescale 1ns/1ns
`default_nettype none
`include "pal_consts.svh"
module pal_axil_slave (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Write address and data
    input wire logic i_axi_awvalid,
    input wire logic [`PAL_ADDR_W-1:0] i_axi_awaddr,
    output logic o_axi_awready,
    input wire logic i_axi_wvalid,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    output logic o_axi_wready,
    // Write response
    output logic o_axi_bvalid,
    output logic [1:0] o_axi_bresp,
    input wire logic i_axi_bready,
    // Read address and data
    input wire logic i_axi_arvalid,
    input wire logic [`PAL_ADDR_W-1:0] i_axi_araddr,
    output logic o_axi_arready,
    output logic o_axi_rvalid,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    input wire logic i_axi_rready,
    // Register file side
    output pal_pkg::pal_wr_s o_wr,
    input wire logic i_wr_ok,
    output logic [`PAL_ADDR_W-1:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_ok
);

    logic aw_full, w_full, ar_full;
    logic next_aw_full, next_w_full, next_ar_full;
    logic [`PAL_ADDR_W-1:0] aw_addr, next_aw_addr, ar_addr, next_ar_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always_comb begin
        do_write = aw_full && w_full && !o_axi_bvalid;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = o_axi_bvalid;
        next_bresp = o_axi_bresp;
        if (i_axi_awvalid && o_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = i_axi_awaddr;
        end
        if (i_axi_wvalid && o_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = i_axi_wdata;
            next_w_strb = i_axi_wstrb;
        end
        if (o_axi_bvalid && i_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = i_wr_ok ? `PAL_RESP_OKAY : `PAL_RESP_SLVERR;
        end
        // Ready only while the holding slot stays empty
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
        o_wr = '{en: do_write, addr: aw_addr, data: w_data, strb: w_strb};
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always_comb begin
        next_ar_full = ar_full;
        next_ar_addr = ar_addr;
        next_rvalid = o_axi_rvalid;
        next_rdata = o_axi_rdata;
        next_rresp = o_axi_rresp;
        o_rd_addr = ar_addr;
        if (i_axi_arvalid && o_axi_arready) begin
            next_ar_full = 1'b1;
            next_ar_addr = i_axi_araddr;
        end
        if (o_axi_rvalid && i_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_full && !o_axi_rvalid) begin
            next_ar_full = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = i_rd_ok ? i_rd_data : 32'h0000_0000;
            next_rresp = i_rd_ok ? `PAL_RESP_OKAY : `PAL_RESP_SLVERR;
        end
        next_arready = !next_ar_full && !next_rvalid;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            ar_full <= 1'b0;
            aw_addr <= '0;
            ar_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_axi_awready <= 1'b0;
            o_axi_wready <= 1'b0;
            o_axi_arready <= 1'b0;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp <= `PAL_RESP_OKAY;
            o_axi_rvalid <= 1'b0;
            o_axi_rdata <= 32'h0000_0000;
            o_axi_rresp <= `PAL_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            ar_full <= next_ar_full;
            aw_addr <= next_aw_addr;
            ar_addr <= next_ar_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            o_axi_awready <= next_awready;
            o_axi_wready <= next_wready;
            o_axi_arready <= next_arready;
            o_axi_bvalid <= next_bvalid;
            o_axi_bresp <= next_bresp;
            o_axi_rvalid <= next_rvalid;
            o_axi_rdata <= next_rdata;
            o_axi_rresp <= next_rresp;
        end
    end

endmodule
`default_nettype wire

// *** logic/pal_pin_mux.sv ***
// Port A low pin function selector: register file and pin routing.
// Assumes port data and serial peripherals on the same clock; pins and
// the operating-mode strap arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "pal_consts.svh"
module pal_pin_mux (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // AXI4-Lite slave
    input wire logic i_axi_awvalid,
    input wire logic [`PAL_ADDR_W-1:0] i_axi_awaddr,
    output logic o_axi_awready,
    input wire logic i_axi_wvalid,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    output logic o_axi_wready,
    output logic o_axi_bvalid,
    output logic [1:0] o_axi_bresp,
    input wire logic i_axi_bready,
    input wire logic i_axi_arvalid,
    input wire logic [`PAL_ADDR_W-1:0] i_axi_araddr,
    output logic o_axi_arready,
    output logic o_axi_rvalid,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    input wire logic i_axi_rready,
    // Operating-mode strap: 0 mode 2, 1 single-chip mode 3
    input wire logic i_mode_single_chip,
    // Pins 3..0 and pin 15
    input wire logic [3:0] i_pin_in,
    output logic [3:0] o_pin_out,
    output logic [3:0] o_pin_oe,
    input wire logic i_pin15_in,
    output logic o_pin15_out,
    output logic o_pin15_oe,
    // Port I/O side
    input wire logic [3:0] i_port_dout,
    input wire logic [3:0] i_port_dir,
    input wire logic i_port_a_bit_15_dout,
    input wire logic i_port_a_bit_15_dir,
    output logic [3:0] o_port_din,
    output logic o_port_a_bit_15_din,
    // Peripheral side
    input wire logic i_bus_clk_out,
    input wire logic i_serial0_transmit_out,
    input wire logic i_serial0_clock_out,
    input wire logic i_serial0_clock_oe,
    output logic o_serial0_clock_io_in,
    output logic o_serial1_receive_in,
    output logic o_ext_interrupt_0_in,
    output logic o_ext_interrupt_1_in,
    output logic o_output_disable_req_1_in,
    output logic o_output_disable_req_2_in,
    output logic o_ext_bus_mode
);

    // ----------------------------------------
    // Synchronised inputs
    // ----------------------------------------
    logic [5:0] sync_q;
    logic [3:0] pin_lvl;
    logic pin15_lvl, strap_lvl;

    pal_sync #(
        .W(6)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_mode_single_chip, i_pin15_in, i_pin_in}),
        .o_sync(sync_q)
    );

    assign pin_lvl = sync_q[3:0];
    assign pin15_lvl = sync_q[4];
    assign strap_lvl = sync_q[5];

    // ----------------------------------------
    // Bus front end
    // ----------------------------------------
    pal_pkg::pal_wr_s wr;
    logic wr_ok, rd_ok;
    logic [`PAL_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;

    pal_axil_slave u_axil (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_axi_awvalid(i_axi_awvalid),
        .i_axi_awaddr(i_axi_awaddr),
        .o_axi_awready(o_axi_awready),
        .i_axi_wvalid(i_axi_wvalid),
        .i_axi_wdata(i_axi_wdata),
        .i_axi_wstrb(i_axi_wstrb),
        .o_axi_wready(o_axi_wready),
        .o_axi_bvalid(o_axi_bvalid),
        .o_axi_bresp(o_axi_bresp),
        .i_axi_bready(i_axi_bready),
        .i_axi_arvalid(i_axi_arvalid),
        .i_axi_araddr(i_axi_araddr),
        .o_axi_arready(o_axi_arready),
        .o_axi_rvalid(o_axi_rvalid),
        .o_axi_rdata(o_axi_rdata),
        .o_axi_rresp(o_axi_rresp),
        .i_axi_rready(i_axi_rready),
        .o_wr(wr),
        .i_wr_ok(wr_ok),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ok)
    );

    // ----------------------------------------
    // Register file and mode capture
    // ----------------------------------------
    logic [15:0] fsel, next_fsel;
    logic p15_clk_sel, next_p15_clk_sel;
    logic single_chip, next_single_chip;
    logic mode_caught, next_mode_caught;
    logic [1:0] strap_cnt, next_strap_cnt;
    logic [15:0] wr_merged;

    always_comb begin
        wr_ok = (wr.addr == `PAL_OFS_FSEL) || (wr.addr == `PAL_OFS_P15) || (wr.addr == `PAL_OFS_STAT);
        rd_ok = (rd_addr == `PAL_OFS_FSEL) || (rd_addr == `PAL_OFS_P15) || (rd_addr == `PAL_OFS_STAT);
        wr_merged = {wr.strb[1] ? wr.data[15:8] : fsel[15:8], wr.strb[0] ? wr.data[7:0] : fsel[7:0]};
        next_fsel = fsel;
        next_p15_clk_sel = p15_clk_sel;
        next_single_chip = single_chip;
        next_mode_caught = mode_caught;
        next_strap_cnt = strap_cnt;
        // Strap settles through the synchroniser before it is caught
        if (!mode_caught) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == `PAL_STRAP_WAIT) begin
                next_mode_caught = 1'b1;
                next_single_chip = strap_lvl;
                next_p15_clk_sel = !strap_lvl;
            end
        end
        if (wr.en && wr.addr == `PAL_OFS_FSEL) begin
            next_fsel = wr_merged & `PAL_FSEL_RW_MASK;
        end
        if (wr.en && wr.addr == `PAL_OFS_P15 && wr.strb[0] && mode_caught) begin
            // Clock choice is gone in single-chip mode
            next_p15_clk_sel = wr.data[`PAL_P15_CLK_BIT] && !single_chip;
        end
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `PAL_OFS_FSEL: rd_data[15:0] = fsel & `PAL_FSEL_RW_MASK;
            `PAL_OFS_P15: rd_data[`PAL_P15_CLK_BIT] = p15_clk_sel;
            `PAL_OFS_STAT: begin
                rd_data[`PAL_STAT_SINGLE_BIT] = single_chip;
                rd_data[`PAL_STAT_CAUGHT_BIT] = mode_caught;
                rd_data[`PAL_STAT_LEVEL_LSB +: 4] = pin_lvl;
                rd_data[`PAL_STAT_P15_LEVEL_BIT] = pin15_lvl;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            fsel <= `PAL_FSEL_RESET;
            p15_clk_sel <= 1'b0;
            single_chip <= 1'b0;
            mode_caught <= 1'b0;
            strap_cnt <= 2'h0;
        end else begin
            fsel <= next_fsel;
            p15_clk_sel <= next_p15_clk_sel;
            single_chip <= next_single_chip;
            mode_caught <= next_mode_caught;
            strap_cnt <= next_strap_cnt;
        end
    end

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    pal_pkg::pal_drv_s [3:0] drv;
    pal_pkg::pal_drv_s drv15;
    pal_pkg::pal_code_e code3, code2, code1, code0;
    logic next_sck_in, next_rx1_in, next_ext_interrupt_0_in_in, next_ext_interrupt_1_in_in, next_output_disable_req_1_in_in, next_output_disable_req_2_in_in;

    always_comb begin
        code3 = pal_pkg::pal_code_e'(fsel[`PAL_FSEL_PIN3_LSB +: 3]);
        code2 = pal_pkg::pal_code_e'(fsel[`PAL_FSEL_PIN2_LSB +: 3]);
        code1 = pal_pkg::pal_code_e'(fsel[`PAL_FSEL_PIN1_LSB +: 3]);
        code0 = pal_pkg::pal_code_e'(fsel[`PAL_FSEL_PIN0_LSB +: 3]);
        // Unused peripheral inputs sit at their idle level
        next_sck_in = `PAL_IDLE_IN;
        next_rx1_in = `PAL_IDLE_IN;
        next_ext_interrupt_0_in_in = `PAL_IDLE_IN;
        next_ext_interrupt_1_in_in = `PAL_IDLE_IN;
        next_output_disable_req_1_in_in = `PAL_IDLE_IN;
        next_output_disable_req_2_in_in = `PAL_IDLE_IN;
        for (int i = 0; i < 4; i++) begin
            // Forbidden codes release the pin rather than guess a function
            drv[i] = '{dout: i_port_dout[i], oe: 1'b0};
        end
        if (code0 == pal_pkg::PAL_FN_PORT) begin
            drv[0].oe = i_port_dir[0];
        end
        case (code1)
            pal_pkg::PAL_FN_PORT: drv[1].oe = i_port_dir[1];
            pal_pkg::PAL_FN_ALT1: drv[1] = '{dout: i_serial0_transmit_out, oe: 1'b1};
            pal_pkg::PAL_FN_ALT7: next_output_disable_req_1_in_in = pin_lvl[1];
            default: drv[1].oe = 1'b0;
        endcase
        case (code2)
            pal_pkg::PAL_FN_PORT: drv[2].oe = i_port_dir[2];
            pal_pkg::PAL_FN_ALT1: begin
                drv[2] = '{dout: i_serial0_clock_out, oe: i_serial0_clock_oe};
                next_sck_in = pin_lvl[2];
            end
            pal_pkg::PAL_FN_ALT3: next_ext_interrupt_0_in_in = pin_lvl[2];
            pal_pkg::PAL_FN_ALT7: next_output_disable_req_2_in_in = pin_lvl[2];
            default: drv[2].oe = 1'b0;
        endcase
        case (code3)
            pal_pkg::PAL_FN_PORT: drv[3].oe = i_port_dir[3];
            pal_pkg::PAL_FN_ALT1: next_rx1_in = pin_lvl[3];
            pal_pkg::PAL_FN_ALT7: next_ext_interrupt_1_in_in = pin_lvl[3];
            default: drv[3].oe = 1'b0;
        endcase
        // Pin 15 stays released until the strap has been caught
        if (!mode_caught) begin
            drv15 = '{dout: 1'b0, oe: 1'b0};
        end else if (p15_clk_sel && !single_chip) begin
            drv15 = '{dout: i_bus_clk_out, oe: 1'b1};
        end else begin
            drv15 = '{dout: i_port_a_bit_15_dout, oe: i_port_a_bit_15_dir};
        end
    end

    // Every routed output is one flop behind its field
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_pin_out <= 4'h0;
            o_pin_oe <= 4'h0;
            o_pin15_out <= 1'b0;
            o_pin15_oe <= 1'b0;
            o_port_din <= 4'h0;
            o_port_a_bit_15_din <= 1'b0;
            o_serial0_clock_io_in <= `PAL_IDLE_IN;
            o_serial1_receive_in <= `PAL_IDLE_IN;
            o_ext_interrupt_0_in <= `PAL_IDLE_IN;
            o_ext_interrupt_1_in <= `PAL_IDLE_IN;
            o_output_disable_req_1_in <= `PAL_IDLE_IN;
            o_output_disable_req_2_in <= `PAL_IDLE_IN;
            o_ext_bus_mode <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                o_pin_out[i] <= drv[i].dout;
                o_pin_oe[i] <= drv[i].oe;
            end
            o_pin15_out <= drv15.dout;
            o_pin15_oe <= drv15.oe;
            o_port_din <= pin_lvl;
            o_port_a_bit_15_din <= pin15_lvl;
            o_serial0_clock_io_in <= next_sck_in;
            o_serial1_receive_in <= next_rx1_in;
            o_ext_interrupt_0_in <= next_ext_interrupt_0_in_in;
            o_ext_interrupt_1_in <= next_ext_interrupt_1_in_in;
            o_output_disable_req_1_in <= next_output_disable_req_1_in_in;
            o_output_disable_req_2_in <= next_output_disable_req_2_in_in;
            o_ext_bus_mode <= mode_caught && !single_chip;
        end
    end

endmodule
`default_nettype wire

// *** dv/pal_pin_mux_assertions.sv ***
// Checker of the pin function selector, port-level relations only.
// Assumes it is bound onto pal_pin_mux; one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "pal_consts.svh"
module pal_pin_mux_chk (
    // Clock, reset and bus
    input wire logic i_sys_clk, i_rst_b, i_axi_awvalid, i_axi_wvalid, i_axi_arvalid,
    input wire logic [`PAL_ADDR_W-1:0] i_axi_araddr,
    input wire logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid,
    input wire logic [1:0] o_axi_rresp,
    input wire logic [31:0] o_axi_rdata,
    // Pins and peripherals
    input wire logic i_mode_single_chip, i_port_a_bit_15_dir, o_pin15_oe, o_ext_bus_mode,
    input wire logic [3:0] i_pin_in, o_port_din, o_pin_oe,
    input wire logic o_serial0_clock_io_in, o_serial1_receive_in, o_ext_interrupt_0_in,
    input wire logic o_ext_interrupt_1_in, o_output_disable_req_1_in, o_output_disable_req_2_in
);
    // ----
    // Helper state
    // ----
    logic [`PAL_ADDR_W-1:0] rd_addr;
    logic [2:0] up;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            rd_addr <= 8'h00;
            up <= 3'h0;
        end else begin
            if (i_axi_arvalid && o_axi_arready) rd_addr <= i_axi_araddr;
            if (up != 3'h7) up <= up + 3'h1;
        end
    end
    // ----
    // Properties
    // ----
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_wr_taken;
        i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
    endsequence
    sequence s_fsel_read;
        o_axi_rvalid && rd_addr == `PAL_OFS_FSEL;
    endsequence
    AST_WR_DONE: assert property (s_wr_taken |-> ##[1:2] o_axi_bvalid)
        else $error("write answer late");
    AST_RSV_ZERO: assert property (s_fsel_read |-> (o_axi_rdata & 32'hFFFF8888) == 32'h0)
        else $error("reserved bits not zero");
    AST_UNMAPPED: assert property (o_axi_rvalid && rd_addr > 8'h08 |->
        o_axi_rresp == `PAL_RESP_SLVERR && o_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    // Sync depth of three edges, pipeline full once up passes four
    AST_DIN: assert property (up > 3'h4 |-> o_port_din == $past(i_pin_in, 3))
        else $error("port input lag wrong");
    AST_BUS_MODE: assert property (o_ext_bus_mode |-> !i_mode_single_chip)
        else $error("bus mode in single chip");
    AST_P15_MODE3: assert property (i_mode_single_chip && o_pin15_oe |-> $past(i_port_a_bit_15_dir))
        else $error("pin 15 driven without port");
    AST_P3_ONE: assert property (!o_ext_interrupt_1_in |-> o_serial1_receive_in)
        else $error("pin 3 fed twice");
    AST_P2_ONE: assert property (!o_ext_interrupt_0_in |->
        o_output_disable_req_2_in && o_serial0_clock_io_in)
        else $error("pin 2 fed twice");
    AST_P1_DRIVEN: assert property (o_pin_oe[1] |-> o_output_disable_req_1_in)
        else $error("pin 1 driven and fed");
endmodule
`default_nettype wire

// *** dv/pal_pin_mux_test.sv ***
// Testbench of the port A low pin function selector.
// Assumes design files and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pal_consts.svh"
module pal_pin_mux_test;
    logic i_sys_clk = 1'h0, i_rst_b = 1'h0, i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0;
    logic i_axi_bready = 1'h0, i_axi_arvalid = 1'h0, i_axi_rready = 1'h0, i_mode_single_chip = 1'h0;
    logic i_pin15_in = 1'h1, i_port_a_bit_15_dout = 1'h0, i_port_a_bit_15_dir = 1'h0, i_bus_clk_out = 1'h1;
    logic i_serial0_transmit_out = 1'h1, i_serial0_clock_out = 1'h0, i_serial0_clock_oe = 1'h0;
    logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
    logic [31:0] i_axi_wdata = 32'h0;
    logic [3:0] i_axi_wstrb = 4'h0, i_pin_in = 4'hF, i_port_dout = 4'h0, i_port_dir = 4'h0;
    logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
    logic [1:0] o_axi_bresp, o_axi_rresp;
    logic [31:0] o_axi_rdata;
    logic [3:0] o_pin_out, o_pin_oe, o_port_din;
    logic o_pin15_out, o_pin15_oe, o_port_a_bit_15_din, o_serial0_clock_io_in, o_serial1_receive_in;
    logic o_ext_interrupt_0_in, o_ext_interrupt_1_in, o_output_disable_req_1_in;
    logic o_output_disable_req_2_in, o_ext_bus_mode;
    int n_fail = 0;
    int checks_done = 0;
    localparam logic [15:0] CODE [8] = '{16'h1000, 16'h7000, 16'h2000, 16'h0100, 16'h0300, 16'h0700,
        16'h0070, 16'h0000};
    localparam logic [5:0] PER [8] = '{6'h2F, 6'h3B, 6'h3F, 6'h1F, 6'h37, 6'h3E, 6'h3D, 6'h3F};
    localparam int PIN [8] = '{3, 3, 3, 2, 2, 2, 1, 1};

    pal_pin_mux DUT (.*);
    always #20 i_sys_clk = ~i_sys_clk;
    // ----
    // Bus and compare tasks
    // ----
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        int n;
        aw = 1'h1;
        w = 1'h1;
        b = 1'h0;
        n = 0;
        i_axi_awvalid <= 1'h1;
        i_axi_awaddr <= a;
        i_axi_wvalid <= 1'h1;
        i_axi_wdata <= d;
        i_axi_wstrb <= 4'hF;
        i_axi_bready <= 1'h1;
        while (!b && n < 50) begin
            @(posedge i_sys_clk);
            n++;
            if (aw && o_axi_awready) begin
                aw = 1'h0;
                i_axi_awvalid <= 1'h0;
            end
            if (w && o_axi_wready) begin
                w = 1'h0;
                i_axi_wvalid <= 1'h0;
            end
            if (o_axi_bvalid) begin
                b = 1'h1;
                i_axi_bready <= 1'h0;
                cmp("bresp", er, o_axi_bresp);
            end
        end
        n_fail += !b;
        // One idle edge so bready is not assigned twice in one step
        tk(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        int n;
        ar = 1'h1;
        r = 1'h0;
        n = 0;
        i_axi_arvalid <= 1'h1;
        i_axi_araddr <= a;
        i_axi_rready <= 1'h1;
        while (!r && n < 50) begin
            @(posedge i_sys_clk);
            n++;
            if (ar && o_axi_arready) begin
                ar = 1'h0;
                i_axi_arvalid <= 1'h0;
            end
            if (o_axi_rvalid) begin
                r = 1'h1;
                i_axi_rready <= 1'h0;
                cmp("rdata", ed, o_axi_rdata);
                cmp("rresp", er, o_axi_rresp);
            end
        end
        n_fail += !r;
        tk(1);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset(input logic sc);
        i_mode_single_chip <= sc;
        i_rst_b <= 1'h0;
        tk(8);
        i_rst_b <= 1'h1;
        tk(8);
    endtask
    task automatic t_mode2();
        rd(`PAL_OFS_FSEL, 32'h0, `PAL_RESP_OKAY);
        rd(`PAL_OFS_STAT, 32'h1F2, `PAL_RESP_OKAY);
        rd(`PAL_OFS_P15, 32'h1, `PAL_RESP_OKAY);
        cmp("bus_mode", 1, o_ext_bus_mode);
        cmp("p15", 2'h3, {o_pin15_oe, o_pin15_out});
        wr(`PAL_OFS_FSEL, 32'hFFFF, `PAL_RESP_OKAY);
        rd(`PAL_OFS_FSEL, 32'h7777, `PAL_RESP_OKAY);
    endtask
    // One pin pulled low per code; one peripheral input must follow, none for pin 3 code 2 or all-port
    task automatic t_route();
        for (int k = 0; k < 8; k++) begin
            wr(`PAL_OFS_FSEL, CODE[k], `PAL_RESP_OKAY);
            rd(`PAL_OFS_FSEL, CODE[k], `PAL_RESP_OKAY);
            i_pin_in <= 4'hF ^ (4'h1 << PIN[k]);
            tk(5);
            cmp("periph", PER[k], {o_serial0_clock_io_in, o_serial1_receive_in, o_ext_interrupt_0_in,
                o_ext_interrupt_1_in, o_output_disable_req_1_in, o_output_disable_req_2_in});
            cmp("pin_oe", 0, o_pin_oe[PIN[k]]);
            cmp("din", 4'hF ^ (4'h1 << PIN[k]), o_port_din);
            i_pin_in <= 4'hF;
        end
    endtask
    task automatic t_tx();
        i_port_dir <= 4'h8;
        i_port_dout <= 4'h8;
        wr(`PAL_OFS_FSEL, 32'h0, `PAL_RESP_OKAY);
        cmp("p3", 2'h3, {o_pin_oe[3], o_pin_out[3]});
        cmp("p1_oe", 0, o_pin_oe[1]);
        i_serial0_clock_oe <= 1'h1;
        wr(`PAL_OFS_FSEL, 32'h0110, `PAL_RESP_OKAY);
        cmp("p1", 2'h3, {o_pin_oe[1], o_pin_out[1]});
        cmp("p2", 2'h2, {o_pin_oe[2], o_pin_out[2]});
        cmp("p3_oe", 1, o_pin_oe[3]);
        i_serial0_clock_oe <= 1'h0;
        i_port_dir <= 4'h0;
    endtask
    task automatic t_err();
        wr(8'h40, 32'h1, `PAL_RESP_SLVERR);
        rd(8'h40, 32'h0, `PAL_RESP_SLVERR);
        wr(`PAL_OFS_STAT, 32'h0, `PAL_RESP_OKAY);
        rd(`PAL_OFS_FSEL, 32'h0110, `PAL_RESP_OKAY);
    endtask
    // Single-chip strap: bus clock choice is gone
    task automatic t_mode3();
        t_reset(1'h1);
        cmp("bus_mode", 0, o_ext_bus_mode);
        cmp("p15_oe", 0, o_pin15_oe);
        cmp("p15_din", 1, o_port_a_bit_15_din);
        rd(`PAL_OFS_STAT, 32'h1F3, `PAL_RESP_OKAY);
        wr(`PAL_OFS_P15, 32'h1, `PAL_RESP_OKAY);
        rd(`PAL_OFS_P15, 32'h0, `PAL_RESP_OKAY);
        i_port_a_bit_15_dir <= 1'h1;
        tk(3);
        cmp("p15", 2'h2, {o_pin15_oe, o_pin15_out});
    endtask
    task automatic results();
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        t_reset(1'h0);
        t_mode2();
        t_route();
        t_tx();
        t_err();
        t_mode3();
        results();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule
bind pal_pin_mux pal_pin_mux_chk u_chk (.*);
`default_nettype wire
